/* File: rtl/tmr_osc_pkg.sv */
// shared constants, register map and carrier types for the timer oscillator
package tmr_osc_pkg;
    // register byte offsets
    localparam logic [3:0] OFF_CTRL   = 4'h0;
    localparam logic [3:0] OFF_IRQEN  = 4'h4;
    localparam logic [3:0] OFF_STATUS = 4'h8;
    localparam logic [3:0] OFF_COUNT  = 4'hC;
    // timer_control_reg fields
    localparam int CTRL_ON      = 0;
    localparam int CTRL_OSCEN   = 1;
    localparam int CTRL_SYNCDIS = 2;
    localparam int CTRL_EXTCLK  = 3;
    localparam int CTRL_SYSLP   = 4;
    localparam int CTRL_SLEEP   = 5;
    localparam int CTRL_W       = 6;
    localparam logic [5:0] CTRL_RST = 6'h00;
    // irq enable fields
    localparam int IEN_OVF = 0;
    localparam int IEN_PER = 1;
    localparam int IEN_GLB = 2;
    localparam logic [2:0] IEN_RST = 3'h0;
    // status fields
    localparam int ST_OVF = 0;
    localparam logic [15:0] ISR_VECTOR = 16'h0004;
    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;
    // crystal rate and system clock rate
    localparam int XTAL_HZ  = 32768;
    localparam int CLK_HZ   = 100000000;

    typedef struct packed {
        logic pinHi;
        logic pinLo;
    } pair_s;

    typedef struct packed {
        logic       wake;
        logic       vector;
        logic [15:0] target;
    } wake_s;
endpackage : tmr_osc_pkg

/* File: rtl/edge_sync3.sv */
// three-stage synchroniser with agreed edge detection
module edge_sync3
    import tmr_osc_pkg::*;
(
    // clocking
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic clkEn,
    // async input and result
    input  wire logic asyncIn,
    output logic      level,
    output logic      rise
);
    logic [2:0] stage_ff;
    logic [2:0] nxt_stage;
    logic       lvl_ff;
    logic       nxt_lvl;

    // shift and accept a change once stages two and three agree
    always_comb begin
        nxt_stage = {stage_ff[1:0], asyncIn};
        nxt_lvl   = lvl_ff;
        if (stage_ff[1] == stage_ff[2]) begin
            nxt_lvl = stage_ff[2];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stage_ff <= 3'h0;
            lvl_ff   <= 1'b0;
        end else if (clkEn) begin
            stage_ff <= nxt_stage;
            lvl_ff   <= nxt_lvl;
        end
    end

    assign level = lvl_ff;
    assign rise  = nxt_lvl & ~lvl_ff & clkEn;
endmodule : edge_sync3

/* File: rtl/tmr_osc_sleep.sv */
module tmr_osc_sleep
    import tmr_osc_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // oscillator pins and crystal clock
    input  wire logic        oscInputPin,
    output logic             oscAmpEnable,
    // shared port pins
    input  wire logic [1:0]  sharedPinIn,
    input  wire logic [1:0]  portDirIn,
    output logic [1:0]       portDirOut,
    output logic [1:0]       sharedPinRead,
    // core sleep and wake
    input  wire logic        sleepMode,
    input  wire logic [15:0] sleepNextPc,
    output logic             sysClkRun,
    output logic             wakeReq,
    output logic             vectorTake,
    output logic [15:0]      resumeAddr,
    output logic             irq
);
    localparam int CNT_W = 16;

    // registers
    logic [CTRL_W-1:0] ctrl_ff,  nxt_ctrl;
    logic [2:0]        ien_ff,   nxt_ien;
    logic              ovf_ff,   nxt_ovf;
    logic              mask_ff,  nxt_mask;
    logic [CNT_W-1:0]  cnt_ff,   nxt_cnt;
    logic [31:0]       rdat_ff,  nxt_rdat;
    logic              ack_ff,   nxt_ack;
    logic              osc_ff,   nxt_osc;
    logic [1:0]        dir_ff,   nxt_dir;
    logic [1:0]        pinr_ff,  nxt_pinr;
    logic              run_ff,   nxt_run;
    logic              irq_ff,   nxt_irq;
    logic              wake_ff,  nxt_wake;
    logic              vec_ff,   nxt_vec;
    logic [15:0]       raddr_ff, nxt_raddr;
    logic              prev_ff,  nxt_prev;

    // synchronised crystal clock
    logic xtalLevel;
    logic xtalRise;
    logic busReq;
    logic wrStrobe;
    logic srcOk;
    logic tick;
    logic overflow;
    logic reqEnabled;

    edge_sync3 u_xtal_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .asyncIn (oscInputPin),
        .level   (xtalLevel),
        .rise    (xtalRise)
    );

    // bus strobes, one-cycle answer
    assign busReq   = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wrStrobe = busReq & wb_we_i & wb_sel_i[0];

    // clock source legality and counting tick
    always_comb begin
        srcOk = ctrl_ff[CTRL_SYSLP] & ctrl_ff[CTRL_OSCEN];
        tick  = 1'b0;
        if (ctrl_ff[CTRL_ON] & ctrl_ff[CTRL_EXTCLK] & srcOk) begin
            // async mode keeps counting crystal edges while sleepMode is high
            if (ctrl_ff[CTRL_SYNCDIS]) begin
                tick = xtalRise;
            end else if (!sleepMode) begin
                tick = xtalRise;
            end
        end
        overflow   = tick & (cnt_ff == CNT_MAX);
        reqEnabled = ien_ff[IEN_OVF] & ien_ff[IEN_PER];
    end

    // register writes, counter and overflow flag
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_ien  = ien_ff;
        nxt_mask = mask_ff;
        nxt_cnt  = tick ? cnt_ff + 16'h0001 : cnt_ff;
        nxt_ovf  = ovf_ff;
        if (wrStrobe) begin
            unique case (wb_adr_i)
                OFF_CTRL:   nxt_ctrl = wb_dat_i[CTRL_W-1:0];
                OFF_IRQEN:  begin
                    nxt_ien  = wb_dat_i[2:0];
                    nxt_mask = wb_dat_i[8];
                end
                OFF_STATUS: begin
                    if (wb_dat_i[ST_OVF]) begin
                        nxt_ovf = 1'b0;
                    end
                end
                OFF_COUNT:  nxt_cnt = wb_dat_i[15:0];
                default:    nxt_ctrl = ctrl_ff;
            endcase
        end
        if (overflow) begin
            nxt_ovf = 1'b1;
        end
    end

    // read data and ack
    always_comb begin
        nxt_ack  = busReq;
        nxt_rdat = rdat_ff;
        if (busReq & ~wb_we_i) begin
            unique case (wb_adr_i)
                OFF_CTRL:   nxt_rdat = {26'h0, ctrl_ff};
                OFF_IRQEN:  nxt_rdat = {23'h0, mask_ff, 5'h0, ien_ff};
                OFF_STATUS: nxt_rdat = {31'h0, ovf_ff};
                OFF_COUNT:  nxt_rdat = {16'h0, cnt_ff};
                default:    nxt_rdat = 32'h0000_0000;
            endcase
        end
    end

    // pins, clock run, wake and interrupt
    always_comb begin
        nxt_osc  = ctrl_ff[CTRL_OSCEN];
        nxt_dir  = ctrl_ff[CTRL_OSCEN] ? 2'h3 : portDirIn;
        nxt_pinr = ctrl_ff[CTRL_OSCEN] ? 2'h0 : sharedPinIn;
        nxt_run  = ~sleepMode | (srcOk & ctrl_ff[CTRL_SYSLP]);
        nxt_prev = ovf_ff;
        nxt_wake  = 1'b0;
        nxt_vec   = vec_ff;
        nxt_raddr = raddr_ff;
        if (sleepMode & ovf_ff & ~prev_ff & reqEnabled) begin
            nxt_wake = 1'b1;
            if (ien_ff[IEN_GLB]) begin
                nxt_vec   = 1'b1;
                nxt_raddr = ISR_VECTOR;
            end else begin
                nxt_vec   = 1'b0;
                nxt_raddr = sleepNextPc;
            end
        end
        nxt_irq = ovf_ff & mask_ff;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_ff  <= CTRL_RST;
            ien_ff   <= IEN_RST;
            mask_ff  <= 1'b0;
            ovf_ff   <= 1'b0;
            cnt_ff   <= CNT_RST;
            rdat_ff  <= 32'h0000_0000;
            ack_ff   <= 1'b0;
            osc_ff   <= 1'b0;
            dir_ff   <= 2'h3;
            pinr_ff  <= 2'h0;
            run_ff   <= 1'b1;
            irq_ff   <= 1'b0;
            wake_ff  <= 1'b0;
            vec_ff   <= 1'b0;
            raddr_ff <= 16'h0000;
            prev_ff  <= 1'b0;
        end else if (clkEn) begin
            ctrl_ff  <= nxt_ctrl;
            ien_ff   <= nxt_ien;
            mask_ff  <= nxt_mask;
            ovf_ff   <= nxt_ovf;
            cnt_ff   <= nxt_cnt;
            rdat_ff  <= nxt_rdat;
            ack_ff   <= nxt_ack;
            osc_ff   <= nxt_osc;
            dir_ff   <= nxt_dir;
            pinr_ff  <= nxt_pinr;
            run_ff   <= nxt_run;
            irq_ff   <= nxt_irq;
            wake_ff  <= nxt_wake;
            vec_ff   <= nxt_vec;
            raddr_ff <= nxt_raddr;
            prev_ff  <= nxt_prev;
        end
    end

    assign wb_dat_o      = rdat_ff;
    assign wb_ack_o      = ack_ff;
    assign oscAmpEnable  = osc_ff;
    assign portDirOut    = dir_ff;
    assign sharedPinRead = pinr_ff;
    assign sysClkRun     = run_ff;
    assign wakeReq       = wake_ff;
    assign vectorTake    = vec_ff;
    assign resumeAddr    = raddr_ff;
    assign irq           = irq_ff;
endmodule : tmr_osc_sleep

/* File: sim/xtal_model.sv */
// watch crystal seen from the oscillator pins
module xtal_model (
    // amplifier drive and crystal output
    input wire logic drive,
    output logic     xtal
);
    timeunit 1ns;
    timeprecision 100ps;
    // 125 ns swing while driven, even in sleep; stands low otherwise
    initial xtal = 1'b0;
    always begin
        #62.5;
        xtal = drive ? ~xtal : 1'b0;
    end
endmodule : xtal_model

/* File: sim/tmr_osc_monitor.sv */
// checker bound to the timer oscillator block
module tmr_osc_monitor
    import tmr_osc_pkg::*;
(
    // clock and reset
    input wire logic        clock,
    input wire logic        sys_rst,
    // bus
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // pins and core
    input wire logic        oscAmpEnable,
    input wire logic [1:0]  portDirIn,
    input wire logic [1:0]  portDirOut,
    input wire logic [1:0]  sharedPinRead,
    input wire logic        sleepMode,
    input wire logic [15:0] sleepNextPc,
    input wire logic        sysClkRun,
    input wire logic        wakeReq,
    input wire logic        vectorTake,
    input wire logic [15:0] resumeAddr,
    input wire logic        irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // status flag cleared over the bus
    wire stClear = wb_ack_o && wb_we_i && wb_sel_i[0]
        && wb_adr_i == OFF_STATUS && wb_dat_i[ST_OVF];
    // properties
    property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack held");
    property p_unmap; wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0
        |-> wb_dat_o == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped data");
    property p_pins; oscAmpEnable && $past(oscAmpEnable)
        |-> portDirOut == 2'h3 && sharedPinRead == 2'h0; endproperty
    a_pins: assert property (p_pins) else $error("pins free");
    property p_dir; !oscAmpEnable && !$past(oscAmpEnable) && !$past(sys_rst)
        |-> portDirOut == $past(portDirIn); endproperty
    a_dir: assert property (p_dir) else $error("dir forced");
    property p_run; !$past(sleepMode) |-> sysClkRun; endproperty
    a_run: assert property (p_run) else $error("clock stopped");
    property p_wake; wakeReq |-> $past(sleepMode) ##1 !wakeReq; endproperty
    a_wake: assert property (p_wake) else $error("bad wake");
    property p_dest; wakeReq |-> vectorTake ? resumeAddr == ISR_VECTOR
        : resumeAddr == $past(sleepNextPc); endproperty
    a_dest: assert property (p_dest) else $error("bad resume");
    property p_clr; stClear |-> ##[1:2] !irq; endproperty
    a_clr: assert property (p_clr) else $error("irq kept");
    // main scenarios
    c_vec: cover property (wakeReq ##1 vectorTake);
    c_next: cover property (wakeReq ##1 !vectorTake);
    c_irq: cover property ($rose(irq));
endmodule : tmr_osc_monitor

bind tmr_osc_sleep tmr_osc_monitor i_tmr_osc_monitor (.*);

/* File: sim/tmr_osc_sleep_test.sv */
// self-checking bench for the timer oscillator block
module tmr_osc_sleep_test
    import tmr_osc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock = 1'b0;
    logic        sysRst, cyc, stb, wrEn, sleep, ack, amp, xtal;
    logic        clkRun, wake, vect, irq;
    logic        clkEn = 1'b1;
    logic [3:0]  adr;
    logic [1:0]  dirIn, pinIn, dirOut, pinRd;
    logic [15:0] nextPc, resume;
    logic [31:0] wdat, rdat, q, c0;
    logic [31:0] m [4];
    logic [31:0] seed = 32'h984CBDFE;
    int          n_errors = 0;
    int          n_checks = 0;
    int          n;
    localparam logic [31:0] MK [4] = '{32'h3F, 32'h107, 32'h0, 32'hFFFF};
    // clock
    initial begin
        forever #5 clock = ~clock;
    end
    // design and crystal
    tmr_osc_sleep i_tmr_osc_sleep (.clock(clock), .sys_rst(sysRst),
        .clkEn(clkEn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wrEn),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .oscInputPin(xtal), .oscAmpEnable(amp),
        .sharedPinIn(pinIn), .portDirIn(dirIn), .portDirOut(dirOut),
        .sharedPinRead(pinRd), .sleepMode(sleep), .sleepNextPc(nextPc),
        .sysClkRun(clkRun), .wakeReq(wake), .vectorTake(vect),
        .resumeAddr(resume), .irq(irq));
    xtal_model i_xtal_model (.drive(amp), .xtal(xtal));
    // helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        n = 0;
        {cyc, stb, wrEn, adr, wdat} <= {2'b11, w, a, d};
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            n_errors++;
            $display("Error t=%0t got %h exp %h", $time, ack, 1'b1);
        end
        q = rdat;
        {cyc, stb} <= 2'b00;
        @(posedge clock);
    endtask : wb
    task automatic wm(input logic [1:0] i, input logic [31:0] d);
        wb(1'b1, {i, 2'b00}, d);
        m[i] = d & MK[i];
    endtask : wm
    task automatic rd(input logic [1:0] i, input logic [31:0] e);
        wb(1'b0, {i, 2'b00}, 32'h0);
        chk(q, e);
    endtask : rd
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    // watchdog
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        report_and_stop();
    end
    // tests
    initial begin
        {sysRst, cyc, stb, wrEn, sleep, adr, wdat} = {5'b10000, 36'h0};
        {dirIn, pinIn, nextPc} = 20'h0;
        m = '{default: 32'h0};
        repeat (6) @(posedge clock);
        sysRst <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 4; i++) rd(i[1:0], 32'h0);
        wb(1'b1, 4'h2, 32'hFFFFFFFF);
        wb(1'b0, 4'h2, 32'h0);
        chk(q, 32'h0);
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            if (k == 4) wm(0, 32'h02);
            c0 = xs();
            {dirIn, pinIn} <= c0[3:0];
            repeat (3) @(posedge clock);
            chk(amp, k > 3);
            chk(dirOut, k > 3 ? 2'h3 : c0[3:2]);
            chk(pinRd, k > 3 ? 2'h0 : c0[1:0]);
        end
        $display("test pins done");
        wm(3, 32'h1234);
        wm(0, 32'h0B);
        repeat (200) @(posedge clock);
        rd(3, m[3]);
        wm(0, 32'h1B);
        repeat (200) @(posedge clock);
        wb(1'b0, 4'hC, 32'h0);
        chk(q - m[3] inside {[14:19]}, 1'b1);
        sleep <= 1'b1;
        repeat (10) @(posedge clock);
        wb(1'b0, 4'hC, 32'h0);
        c0 = q;
        repeat (200) @(posedge clock);
        rd(3, c0);
        chk(clkRun, 1'b1);
        wm(0, 32'h0B);
        repeat (3) @(posedge clock);
        chk(clkRun, 1'b0);
        sleep <= 1'b0;
        $display("test count done");
        wm(0, 32'h1F);
        // clock enable low freezes the running counter
        wb(1'b0, 4'hC, 32'h0);
        c0 = q;
        clkEn <= 1'b0;
        repeat (100) @(posedge clock);
        clkEn <= 1'b1;
        @(posedge clock);
        wb(1'b0, 4'hC, 32'h0);
        chk(q - c0 inside {[0:2]}, 1'b1);
        for (int g = 0; g < 2; g++) begin
            c0 = xs();
            nextPc <= c0[15:0];
            wm(3, 32'hFFF0);
            wm(1, g ? 32'h107 : 32'h003);
            sleep <= 1'b1;
            n = 0;
            while (wake !== 1'b1 && n < 1000) begin
                @(posedge clock);
                n++;
            end
            chk(wake, 1'b1);
            repeat (2) @(posedge clock);
            chk(vect, g);
            chk(resume, g ? 16'h0004 : c0[15:0]);
            sleep <= 1'b0;
            rd(2, 32'h1);
            chk(irq, g);
            wm(2, 32'h1);
            repeat (3) @(posedge clock);
            chk(irq, 1'b0);
        end
        $display("test wake done");
        report_and_stop();
    end
endmodule : tmr_osc_sleep_test
